// ===== shared/fcgs_map.svh
// Register offsets, field positions, command codes and timing counts of the flash command guard
`ifndef FCGS_MAP_SVH
`define FCGS_MAP_SVH
// How it works
// - Array write before divider set: access error
// - Byte, halfword or misaligned array write: access error
// - Broken write order aborts with access error
// - Undefined command: access error unless protected
// - Non-burst command while burst pending: access error
// - Secured: insecure or debug source limited commands
// - Writing zero to buffer-empty aborts sequence
// - Stop while busy aborts, purges buffered burst
// - Reads never raise access error
// - Protected target or protected mass erase: violation
// - Wait mode lets commands finish
// - Stop kills high voltage, sets complete, error
// - Stop exit sets buffer-empty, drops buffer
// - Debug: protection writable, secured limits commands
// - Ordered key writes matching stored keys unlock
// - Any key misstep locks until reset
// - Unlock leaves stored bytes untouched
// - Reset loads nonvolatile bytes holding the CPU
// - Reset halts running command at once
// - Pulses timed in whole divided clock periods
// - Security field 1:0 means open; debug bit
// - Complete only when active and buffered done

// Register byte offsets
`define FCGS_REG_DIV 16'h0000
`define FCGS_REG_CFG 16'h0004
`define FCGS_REG_PROT 16'h0008
`define FCGS_REG_CMD 16'h000c
`define FCGS_REG_STAT 16'h0010
`define FCGS_REG_OPT 16'h0014
`define FCGS_REG_CTRL 16'h0018
`define FCGS_ARRAY_BIT 15
// Backdoor key addresses inside the array window
`define FCGS_KEY0_ADDR 15'h7ff0
`define FCGS_KEY1_ADDR 15'h7ff4
// Field positions
`define FCGS_STAT_BEF 7
`define FCGS_STAT_CCF 6
`define FCGS_STAT_PVIOL 5
`define FCGS_STAT_ACCERR 4
`define FCGS_CFG_KEY_ACCESS_BIT 5
`define FCGS_PROT_EN 7
`define FCGS_DIV_LOADED 11
// Command codes
`define FCGS_CMD_VERIFY 8'h05
`define FCGS_CMD_PGM 8'h20
`define FCGS_CMD_BURST 8'h25
`define FCGS_CMD_SECT 8'h40
`define FCGS_CMD_MASS 8'h41
// Security encodings
`define FCGS_SEC_OPEN 2'h2
`define FCGS_KEY_UNLOCK_ENABLE_ON 2'h2
// Nonvolatile load: word count and index of each item
`define FCGS_NV_WORDS 3'h5
`define FCGS_NV_CTRL 3'h0
`define FCGS_NV_PROT 3'h1
`define FCGS_NV_OPT 3'h2
`define FCGS_NV_KEY0 3'h3
`define FCGS_NV_KEY1 3'h4
// Timing clock periods per operation
`define FCGS_TICKS_PGM 8'h09
`define FCGS_TICKS_SECT 8'h3f
`define FCGS_TICKS_MASS 8'h7f
`define FCGS_TICKS_VERIFY 8'h20
`endif

// ===== shared/fcgs_pkg.sv
// Types of the flash command guard: sequence and key states and the state record
`default_nettype none
package fcgs_pkg;
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_ADDR = 3'b010,
        SEQ_CMD = 3'b100
    } fcgs_seq_t;

    typedef enum logic [2:0] {
        KEY_WAIT = 3'b001,
        KEY_HALF = 3'b010,
        KEY_LOCK = 3'b100
    } fcgs_key_t;

    typedef struct packed {
        logic loading;
        logic [2:0] ldIdx;
        logic nvRdEn;
        logic [2:0] nvRdIdx;
        logic cpuHold;
        logic [31:0] ctrlParam;
        logic [7:0] prot;
        logic [7:0] stored_option_byte;
        logic [63:0] keys;
        logic [10:0] div;
        logic divLoaded;
        logic key_access_bit;
        logic protWritten;
        fcgs_seq_t seq;
        logic [14:0] seqAddr;
        logic [31:0] seqData;
        logic [7:0] cmd;
        logic bef;
        logic ccf;
        logic accErr;
        logic pviol;
        logic active;
        logic [7:0] actCmd;
        logic [14:0] actAddr;
        logic [31:0] actData;
        logic hvOn;
        logic bufV;
        logic [31:0] bufData;
        logic [10:0] preCnt;
        logic [7:0] tickCnt;
        fcgs_key_t keySt;
        logic unlocked;
        logic keyWrPrev;
        logic dbgSecured;
        logic stopPrev;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } fcgs_state_t;
endpackage
`default_nettype wire

// ===== hdl/fcgs_core.sv
// Flash command write guard, security unlock, reset load and pulse timer with APB registers
`timescale 1ns/1ps
`default_nettype none
`include "fcgs_map.svh"
module fcgs_core (
    input wire logic ref_clk, // 250 MHz clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [15:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic pready, // APB ready
    output logic [31:0] prdata, // APB read data
    output logic pslverr, // APB error
    input wire logic [31:0] arrRdData, // Array word at paddr
    input wire logic [31:0] nvRdData, // Nonvolatile word, while the request stands
    output logic nvRdEn, // Nonvolatile read request
    output logic [2:0] nvRdIdx, // Nonvolatile word index
    output logic cpuHold, // Holds CPU during reset load
    input wire logic stopMode, // CPU in stop mode
    input wire logic dbgMode, // Background debug active
    input wire logic srcSecure, // Write comes from secure memory
    output logic hvOn, // High voltage enable
    output logic algoRun, // Algorithm running
    output logic [7:0] algoCmd, // Running command code
    output logic [14:0] algoAddr, // Running array offset
    output logic [31:0] algoData, // Running program data
    output logic dbgSecured // Debug status: secured
);
    fcgs_pkg::fcgs_state_t st_ff;
    fcgs_pkg::fcgs_state_t nxt_st;
    logic wrFire;
    logic rdPhase;
    logic isArr;
    logic [14:0] arrOff;
    logic keyPath;
    logic secured;
    logic tick;
    logic opDone;
    logic cmdProt;
    logic keyBad;

    // Address inside protected region (upper part above boundary)
    function automatic logic fcgs_is_prot(input logic [7:0] p, input logic [14:0] a);
        fcgs_is_prot = p[`FCGS_PROT_EN] && (a[14:8] >= p[6:0]);
    endfunction

    // Defined command codes
    function automatic logic fcgs_cmd_ok(input logic [7:0] c);
        fcgs_cmd_ok = (c == `FCGS_CMD_VERIFY) || (c == `FCGS_CMD_PGM) ||
            (c == `FCGS_CMD_BURST) || (c == `FCGS_CMD_SECT) || (c == `FCGS_CMD_MASS);
    endfunction

    // Timing clock periods for a command
    function automatic logic [7:0] fcgs_ticks(input logic [7:0] c);
        case (c)
            `FCGS_CMD_PGM: fcgs_ticks = `FCGS_TICKS_PGM;
            `FCGS_CMD_BURST: fcgs_ticks = `FCGS_TICKS_PGM;
            `FCGS_CMD_SECT: fcgs_ticks = `FCGS_TICKS_SECT;
            `FCGS_CMD_MASS: fcgs_ticks = `FCGS_TICKS_MASS;
            default: fcgs_ticks = `FCGS_TICKS_VERIFY;
        endcase
    endfunction

    // Bus decode and shared conditions
    assign wrFire = psel && penable && pwrite && st_ff.pready;
    assign rdPhase = psel && penable && !st_ff.pready;
    assign isArr = paddr[`FCGS_ARRAY_BIT];
    assign arrOff = paddr[14:0];
    assign keyPath = st_ff.key_access_bit && ((arrOff == `FCGS_KEY0_ADDR) || (arrOff == `FCGS_KEY1_ADDR));
    assign secured = (st_ff.stored_option_byte[1:0] != `FCGS_SEC_OPEN) && !st_ff.unlocked;
    assign tick = (st_ff.preCnt == st_ff.div);
    assign opDone = st_ff.active && tick && (st_ff.tickCnt == fcgs_ticks(st_ff.actCmd) - 8'h01);
    assign cmdProt = fcgs_is_prot(st_ff.prot, st_ff.seqAddr);
    assign keyBad = (pwdata == 32'h00000000) || (pwdata == 32'hffffffff) || st_ff.keyWrPrev;

    // Next state of the whole block
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.nvRdEn = 1'b0;
        nxt_st.keyWrPrev = 1'b0;
        nxt_st.stopPrev = stopMode;
        nxt_st.pready = 1'b0;
        // Reset load of nonvolatile words, CPU held meanwhile
        if (st_ff.loading)
        begin
            if (st_ff.ldIdx < `FCGS_NV_WORDS)
            begin
                nxt_st.nvRdEn = 1'b1;
                nxt_st.nvRdIdx = st_ff.ldIdx;
                nxt_st.ldIdx = st_ff.ldIdx + 3'h1;
            end
            if (st_ff.nvRdEn)
            begin
                case (st_ff.nvRdIdx)
                    `FCGS_NV_CTRL: nxt_st.ctrlParam = nvRdData;
                    `FCGS_NV_PROT: nxt_st.prot = nvRdData[7:0];
                    `FCGS_NV_OPT: nxt_st.stored_option_byte = nvRdData[7:0];
                    `FCGS_NV_KEY0: nxt_st.keys[63:32] = nvRdData;
                    default: nxt_st.keys[31:0] = nvRdData;
                endcase
                if (st_ff.nvRdIdx == `FCGS_NV_KEY1)
                begin
                    nxt_st.loading = 1'b0;
                    nxt_st.cpuHold = 1'b0;
                end
            end
        end
        // First access cycle: read data latched, ready raised next cycle
        if (rdPhase)
        begin
            nxt_st.pready = 1'b1;
            nxt_st.pslverr = 1'b0;
            nxt_st.prdata = 32'h00000000;
            if (!pwrite && isArr)
                nxt_st.prdata = st_ff.ccf ? arrRdData : 32'h00000000;
            else if (!pwrite)
            begin
                case (paddr)
                    `FCGS_REG_DIV: nxt_st.prdata = {20'h00000, st_ff.divLoaded, st_ff.div};
                    `FCGS_REG_CFG: nxt_st.prdata = {26'h0000000, st_ff.key_access_bit, 5'h00};
                    `FCGS_REG_PROT: nxt_st.prdata = {24'h000000, st_ff.prot};
                    `FCGS_REG_CMD: nxt_st.prdata = {24'h000000, st_ff.cmd};
                    `FCGS_REG_STAT: nxt_st.prdata = {24'h000000, st_ff.bef, st_ff.ccf,
                        st_ff.pviol, st_ff.accErr, 4'h0};
                    `FCGS_REG_OPT: nxt_st.prdata = {23'h000000, secured, st_ff.stored_option_byte};
                    `FCGS_REG_CTRL: nxt_st.prdata = st_ff.ctrlParam;
                    default: nxt_st.pslverr = 1'b1;
                endcase
            end
            else if (!isArr && !(paddr inside {`FCGS_REG_DIV, `FCGS_REG_CFG, `FCGS_REG_PROT,
                `FCGS_REG_CMD, `FCGS_REG_STAT}))
                nxt_st.pslverr = 1'b1;
        end
        // Array writes: backdoor keys or start of a command sequence
        if (wrFire && isArr && !st_ff.loading && !stopMode)
        begin
            if (keyPath)
            begin
                if (st_ff.stored_option_byte[7:6] == `FCGS_KEY_UNLOCK_ENABLE_ON && secured && !dbgMode
                    && st_ff.keySt != fcgs_pkg::KEY_LOCK)
                begin
                    nxt_st.keyWrPrev = 1'b1;
                    if (st_ff.keySt == fcgs_pkg::KEY_WAIT && arrOff == `FCGS_KEY0_ADDR
                        && pwdata == st_ff.keys[63:32] && !keyBad)
                        nxt_st.keySt = fcgs_pkg::KEY_HALF;
                    else if (st_ff.keySt == fcgs_pkg::KEY_HALF && arrOff == `FCGS_KEY1_ADDR
                        && pwdata == st_ff.keys[31:0] && !keyBad)
                    begin
                        nxt_st.keySt = fcgs_pkg::KEY_WAIT;
                        nxt_st.unlocked = 1'b1;
                    end
                    else
                        nxt_st.keySt = fcgs_pkg::KEY_LOCK;
                end
            end
            else if (st_ff.seq != fcgs_pkg::SEQ_IDLE)
            begin
                nxt_st.accErr = 1'b1;
                nxt_st.seq = fcgs_pkg::SEQ_IDLE;
            end
            else if (!st_ff.divLoaded || pstrb != 4'hf || paddr[1:0] != 2'h0 || !st_ff.bef)
                nxt_st.accErr = 1'b1;
            else if (!st_ff.accErr && !st_ff.pviol)
            begin
                nxt_st.seq = fcgs_pkg::SEQ_ADDR;
                nxt_st.seqAddr = arrOff;
                nxt_st.seqData = pwdata;
            end
        end
        // Register writes
        if (wrFire && !isArr && !st_ff.loading && !stopMode)
        begin
            if (paddr == `FCGS_REG_STAT)
            begin
                if (pwdata[`FCGS_STAT_ACCERR])
                    nxt_st.accErr = 1'b0;
                if (pwdata[`FCGS_STAT_PVIOL])
                    nxt_st.pviol = 1'b0;
            end
            if (st_ff.seq == fcgs_pkg::SEQ_ADDR && paddr != `FCGS_REG_CMD)
            begin
                nxt_st.accErr = 1'b1;
                nxt_st.seq = fcgs_pkg::SEQ_IDLE;
            end
            else if (st_ff.seq == fcgs_pkg::SEQ_CMD && paddr != `FCGS_REG_STAT)
            begin
                nxt_st.accErr = 1'b1;
                nxt_st.seq = fcgs_pkg::SEQ_IDLE;
            end
            else
            begin
                case (paddr)
                    `FCGS_REG_DIV:
                    begin
                        nxt_st.div = pwdata[10:0];
                        nxt_st.divLoaded = 1'b1;
                    end
                    `FCGS_REG_CFG:
                    begin
                        nxt_st.key_access_bit = pwdata[`FCGS_CFG_KEY_ACCESS_BIT];
                        if (!pwdata[`FCGS_CFG_KEY_ACCESS_BIT] && st_ff.keySt == fcgs_pkg::KEY_HALF)
                            nxt_st.keySt = fcgs_pkg::KEY_LOCK;
                    end
                    `FCGS_REG_PROT:
                    begin
                        if (dbgMode || !st_ff.protWritten)
                        begin
                            nxt_st.prot = pwdata[7:0];
                            nxt_st.protWritten = 1'b1;
                        end
                    end
                    `FCGS_REG_CMD:
                    begin
                        nxt_st.seq = fcgs_pkg::SEQ_IDLE;
                        if (st_ff.seq == fcgs_pkg::SEQ_ADDR)
                        begin
                            nxt_st.cmd = pwdata[7:0];
                            if (secured && (dbgMode || !srcSecure) &&
                                pwdata[7:0] != `FCGS_CMD_VERIFY && pwdata[7:0] != `FCGS_CMD_MASS)
                                nxt_st.accErr = 1'b1;
                            else if (st_ff.bef && !st_ff.ccf && pwdata[7:0] != `FCGS_CMD_BURST)
                                nxt_st.accErr = 1'b1;
                            else if (!fcgs_cmd_ok(pwdata[7:0]))
                            begin
                                if (cmdProt)
                                    nxt_st.pviol = 1'b1;
                                else
                                    nxt_st.accErr = 1'b1;
                            end
                            else if ((pwdata[7:0] == `FCGS_CMD_MASS && st_ff.prot[`FCGS_PROT_EN])
                                || (cmdProt && (pwdata[7:0] == `FCGS_CMD_PGM ||
                                pwdata[7:0] == `FCGS_CMD_BURST || pwdata[7:0] == `FCGS_CMD_SECT)))
                                nxt_st.pviol = 1'b1;
                            else
                                nxt_st.seq = fcgs_pkg::SEQ_CMD;
                        end
                    end
                    `FCGS_REG_STAT:
                    begin
                        if (st_ff.seq == fcgs_pkg::SEQ_CMD)
                        begin
                            nxt_st.seq = fcgs_pkg::SEQ_IDLE;
                            if (!pwdata[`FCGS_STAT_BEF])
                                nxt_st.accErr = 1'b1;
                            else if (!st_ff.active)
                            begin
                                nxt_st.active = 1'b1;
                                nxt_st.actCmd = st_ff.cmd;
                                nxt_st.actAddr = st_ff.seqAddr;
                                nxt_st.actData = st_ff.seqData;
                                nxt_st.hvOn = (st_ff.cmd != `FCGS_CMD_VERIFY);
                                nxt_st.preCnt = 11'h000;
                                nxt_st.tickCnt = 8'h00;
                            end
                            else
                            begin
                                nxt_st.bufV = 1'b1;
                                nxt_st.bufData = st_ff.seqData;
                                nxt_st.bef = 1'b0;
                            end
                        end
                    end
                    default: nxt_st.seq = st_ff.seq;
                endcase
            end
        end
        // Pulse timer on divided clock; wait mode does not disturb it
        if (st_ff.active)
        begin
            nxt_st.preCnt = tick ? 11'h000 : st_ff.preCnt + 11'h001;
            if (tick)
                nxt_st.tickCnt = st_ff.tickCnt + 8'h01;
            if (opDone)
            begin
                nxt_st.tickCnt = 8'h00;
                if (st_ff.bufV)
                begin
                    nxt_st.bufV = 1'b0;
                    nxt_st.bef = 1'b1;
                    nxt_st.actData = st_ff.bufData;
                    nxt_st.actAddr = st_ff.actAddr + 15'h0004;
                end
                else
                begin
                    nxt_st.active = 1'b0;
                    nxt_st.hvOn = 1'b0;
                end
            end
        end
        // Stop entry aborts everything; stop exit reopens buffer
        if (stopMode && !st_ff.stopPrev)
        begin
            nxt_st.seq = fcgs_pkg::SEQ_IDLE;
            if (st_ff.keySt == fcgs_pkg::KEY_HALF || st_ff.key_access_bit)
                nxt_st.keySt = fcgs_pkg::KEY_LOCK;
            if (st_ff.active)
            begin
                nxt_st.active = 1'b0;
                nxt_st.bufV = 1'b0;
                nxt_st.hvOn = 1'b0;
                nxt_st.accErr = 1'b1;
            end
        end
        if (!stopMode && st_ff.stopPrev)
        begin
            nxt_st.bef = 1'b1;
            nxt_st.bufV = 1'b0;
        end
        nxt_st.ccf = !nxt_st.active && !nxt_st.bufV;
        nxt_st.dbgSecured = (nxt_st.stored_option_byte[1:0] != `FCGS_SEC_OPEN) && !nxt_st.unlocked;
    end

    // State register; reset halts any command and restarts the load
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            st_ff <= '0;
            st_ff.loading <= 1'b1;
            st_ff.cpuHold <= 1'b1;
            st_ff.stored_option_byte <= 8'h00;
            st_ff.seq <= fcgs_pkg::SEQ_IDLE;
            st_ff.keySt <= fcgs_pkg::KEY_WAIT;
            st_ff.bef <= 1'b1;
            st_ff.ccf <= 1'b1;
            st_ff.dbgSecured <= 1'b1;
        end
        else
            st_ff <= nxt_st;
    end

    // Outputs straight from the state register
    assign pready = st_ff.pready;
    assign prdata = st_ff.prdata;
    assign pslverr = st_ff.pslverr;
    assign nvRdEn = st_ff.nvRdEn;
    assign nvRdIdx = st_ff.nvRdIdx;
    assign cpuHold = st_ff.cpuHold;
    assign hvOn = st_ff.hvOn;
    assign algoRun = st_ff.active;
    assign algoCmd = st_ff.actCmd;
    assign algoAddr = st_ff.actAddr;
    assign algoData = st_ff.actData;
    assign dbgSecured = st_ff.dbgSecured;

    // Checks on the guard behaviour
    a_div_guard: assert property (@(posedge ref_clk) disable iff (rst)
        wrFire && isArr && !keyPath && !stopMode && !st_ff.loading && !st_ff.divLoaded
        |=> st_ff.accErr) else $error("array write before divider not flagged");
    a_align_check: assert property (@(posedge ref_clk) disable iff (rst)
        wrFire && isArr && !keyPath && !stopMode && !st_ff.loading
        && st_ff.seq == fcgs_pkg::SEQ_IDLE && (pstrb != 4'hf || paddr[1:0] != 2'h0)
        |=> st_ff.accErr) else $error("narrow or misaligned write not flagged");
    a_seq_break: assert property (@(posedge ref_clk) disable iff (rst)
        wrFire && !isArr && !stopMode && st_ff.seq == fcgs_pkg::SEQ_ADDR
        && paddr != `FCGS_REG_CMD |=> st_ff.accErr && st_ff.seq == fcgs_pkg::SEQ_IDLE)
        else $error("broken sequence not aborted");
    a_mass_prot: assert property (@(posedge ref_clk) disable iff (rst)
        wrFire && !stopMode && paddr == `FCGS_REG_CMD && st_ff.seq == fcgs_pkg::SEQ_ADDR
        && pwdata[7:0] == `FCGS_CMD_MASS && st_ff.prot[`FCGS_PROT_EN] && !secured
        && !(st_ff.bef && !st_ff.ccf) |=> st_ff.pviol) else $error("protected mass erase passed");
    a_stop_abort: assert property (@(posedge ref_clk) disable iff (rst)
        stopMode && !st_ff.stopPrev && st_ff.active
        |=> st_ff.accErr && st_ff.ccf && !st_ff.hvOn && !st_ff.bufV)
        else $error("stop did not abort command");
    a_stop_exit: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(stopMode) |=> st_ff.bef && !st_ff.bufV) else $error("stop exit left buffer");
    a_ccf_done: assert property (@(posedge ref_clk) disable iff (rst)
        st_ff.ccf == !(st_ff.active || st_ff.bufV)) else $error("complete flag wrong");
    a_hold_load: assert property (@(posedge ref_clk)
        $fell(rst) |-> cpuHold [*5]) else $error("CPU released before load");
    a_key_lock: assert property (@(posedge ref_clk) disable iff (rst)
        st_ff.keySt == fcgs_pkg::KEY_LOCK |=> st_ff.keySt == fcgs_pkg::KEY_LOCK && !$rose(st_ff.unlocked))
        else $error("key lock left before reset");
    a_sec_debug: assert property (@(posedge ref_clk) disable iff (rst)
        dbgSecured == ((st_ff.stored_option_byte[1:0] != `FCGS_SEC_OPEN) && !st_ff.unlocked))
        else $error("debug secured bit wrong");
    a_hv_pulse: assert property (@(posedge ref_clk) disable iff (rst)
        opDone && !st_ff.bufV |=> !hvOn && !algoRun) else $error("operation did not end");
endmodule
`default_nettype wire

// ===== tb/fcgs_nv_model.sv
// Nonvolatile store model that feeds the reset load and array reads
`timescale 1ns/1ps
`default_nettype none
module fcgs_nv_model (
    input wire logic nvRdEn, // Load word request
    input wire logic [2:0] nvRdIdx, // Load word index
    output logic [31:0] nvRdData, // Load word while requested
    output logic [31:0] arrRdData // Array word
);
    logic [31:0] nvWord [5] = '{32'h1234_5678, 32'h0000_0000, 32'h0000_0083,
        32'h1111_2222, 32'h3333_4444};
    // Read-only store, so an unlock never alters it; idle cycles show the inverted word
    assign nvRdData = nvRdEn ? nvWord[nvRdIdx] : ~nvWord[nvRdIdx];
    assign arrRdData = 32'h5a5a_a5a5; // Fixed array content
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Bench that drives APB command sequences and checks flags and outputs
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, stopMode = 0, srcSecure = 1;
    logic dbgMode = 0, e;
    logic [15:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, arrRdData, nvRdData, algoData, v;
    logic [3:0] pstrb = '0;
    logic pready, pslverr, nvRdEn, cpuHold, hvOn, algoRun, dbgSecured;
    logic [2:0] nvRdIdx;
    logic [7:0] algoCmd;
    logic [14:0] algoAddr;
    int err_count = 0, samples_checked = 0, cyc = 0;
    fcgs_core dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .arrRdData(arrRdData), .nvRdData(nvRdData),
        .nvRdEn(nvRdEn), .nvRdIdx(nvRdIdx), .cpuHold(cpuHold), .stopMode(stopMode),
        .dbgMode(dbgMode), .srcSecure(srcSecure), .hvOn(hvOn), .algoRun(algoRun),
        .algoCmd(algoCmd), .algoAddr(algoAddr), .algoData(algoData), .dbgSecured(dbgSecured));
    fcgs_nv_model nv (.nvRdEn(nvRdEn), .nvRdIdx(nvRdIdx),
        .nvRdData(nvRdData), .arrRdData(arrRdData));
    // Clock of 4 ns period
    initial
    begin
        forever #2 ref_clk = ~ref_clk;
    end
    // Verdict and end of run
    task automatic wrap_up();
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Hang guard
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer held until pready is sampled high
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
        input logic [3:0] s);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
        begin
            @(posedge ref_clk);
        end
        v = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hf);
    endtask
    // Status check of the error flag, then clear it by writing one
    task automatic acc_err();
        apb(1'b0, 16'h0010, '0, 4'h0);
        chk(v & 32'h10, 32'h10);
        wr(16'h0010, 32'h30);
        apb(1'b0, 16'h0010, '0, 4'h0);
        chk(v & 32'h30, 32'h0);
    endtask
    // Main sequence
    initial
    begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        while (cpuHold !== 1'b0) @(posedge ref_clk);
        apb(1'b0, 16'h0018, '0, 4'h0);
        chk(v, 32'h1234_5678);
        apb(1'b0, 16'h0014, '0, 4'h0);
        chk(v & 32'h1ff, 32'h183);
        chk(dbgSecured, 1'b1);
        wr(16'h8100, 32'h1); // Array write before the divider is set
        acc_err();
        wr(16'h0000, 32'h4e1); // 1250 clocks a period: 200 kHz
        apb(1'b0, 16'h0000, '0, 4'h0);
        chk(v[11], 1'b1);
        apb(1'b1, 16'h8100, 32'h1, 4'h1); // Byte wide array write
        acc_err();
        wr(16'h8100, 32'h1);
        wr(16'h0004, 32'h0); // Wrong register after the address
        acc_err();
        wr(16'h8100, 32'h1);
        wr(16'h000c, 32'h77);
        acc_err();
        srcSecure <= 1'b0;
        wr(16'h8100, 32'h1);
        wr(16'h000c, 32'h20);
        acc_err();
        srcSecure <= 1'b1;
        wr(16'h8100, 32'h1);
        wr(16'h000c, 32'h20);
        wr(16'h0010, 32'h0); // Abort by writing zero to buffer-empty
        acc_err();
        wr(16'h8100, 32'hcafe_f00d);
        apb(1'b0, 16'h0010, '0, 4'h0); // Register read inside a valid sequence
        chk(v & 32'h10, 32'h0);
        chk(e, 1'b0);
        wr(16'h000c, 32'h20);
        wr(16'h0010, 32'h80);
        chk({algoRun, algoCmd, algoAddr}, {1'b1, 8'h20, 15'h0100});
        chk(algoData, 32'hcafe_f00d);
        apb(1'b0, 16'h0010, '0, 4'h0);
        chk(v & 32'h40, 32'h0);
        repeat (11000) @(posedge ref_clk); // Nine periods of 1250 clocks not yet over
        apb(1'b0, 16'h0010, '0, 4'h0);
        chk(v & 32'h40, 32'h0);
        repeat (300) @(posedge ref_clk);
        apb(1'b0, 16'h0010, '0, 4'h0);
        chk(v & 32'h40, 32'h40);
        wr(16'h8200, 32'h0);
        wr(16'h000c, 32'h40);
        wr(16'h0010, 32'h80);
        stopMode <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk({hvOn, algoRun}, 2'b00);
        stopMode <= 1'b0;
        @(posedge ref_clk);
        apb(1'b0, 16'h0010, '0, 4'h0);
        chk(v & 32'hd0, 32'hd0);
        // Ordered backdoor keys unlock, stored option byte untouched
        wr(16'h0004, 32'h20);
        wr(16'hfff0, 32'h1111_2222);
        wr(16'hfff4, 32'h3333_4444);
        chk(dbgSecured, 1'b0);
        wr(16'h0004, 32'h0);
        apb(1'b0, 16'h0014, '0, 4'h0);
        chk(v & 32'h1ff, 32'h083);
        // Mass erase with protection enabled is a violation
        wr(16'h0010, 32'h30);
        wr(16'h0008, 32'hff);
        wr(16'h8100, 32'h0);
        wr(16'h000c, 32'h41);
        apb(1'b0, 16'h0010, '0, 4'h0);
        chk(v & 32'h30, 32'h20);
        // Debug mode rewrites the protection byte after its one write
        dbgMode <= 1'b1;
        wr(16'h0008, 32'h0);
        apb(1'b0, 16'h0008, '0, 4'h0);
        chk(v, 32'h0);
        dbgMode <= 1'b0;
        // Reset during a program halts it and security follows the stored byte
        wr(16'h0010, 32'h30);
        wr(16'h8100, 32'h1);
        wr(16'h000c, 32'h20);
        wr(16'h0010, 32'h80);
        rst <= 1'b1;
        repeat (16) @(posedge ref_clk);
        chk({algoRun, hvOn}, 2'b00);
        rst <= 1'b0;
        while (cpuHold !== 1'b0) @(posedge ref_clk);
        chk(dbgSecured, 1'b1);
        wrap_up();
    end
endmodule
`default_nettype wire
